// *** common/sow_pkg.sv ***
// Constants, types and state layout shared by the outbound window bridge.
package sow_pkg;
    localparam int ADDR_W = 36;
    localparam int BASE_W = 24;
    localparam int PAGE_SHIFT = 12;
    localparam int MOFS_W = 24;
    localparam int SIZE_W = 6;
    localparam int TGT_W = 4;
    localparam int TT_W = 4;

    // Register byte offsets inside the configuration page.
    localparam logic [11:0] OFS_LW_BASE = 12'h000;
    localparam logic [11:0] OFS_LW_ATTR = 12'h004;
    localparam logic [11:0] OFS_OW_BASE = 12'h008;
    localparam logic [11:0] OFS_OW_ATTR = 12'h00c;
    localparam logic [11:0] OFS_OW_TRANS = 12'h010;
    localparam logic [11:0] OFS_LINK_STAT = 12'h014;

    // Writable bits of each register; the rest read as zero.
    localparam logic [31:0] MASK_BASE = 32'h00ffffff;
    localparam logic [31:0] MASK_LW_ATTR = 32'h80f0003f;
    localparam logic [31:0] MASK_OW_ATTR = 32'h8efff03f;
    localparam logic [31:0] MASK_OW_TRANS = 32'h3fcfffff;
    localparam logic [31:0] REG_RST = 32'h00000000;

    // Field positions, counted from the least significant bit.
    localparam int EN_BIT = 31;
    localparam int LW_TGT_LSB = 20;
    localparam int SIZE_LSB = 0;
    localparam int OW_PRIO_LSB = 26;
    localparam int OW_PCI_BIT = 25;
    localparam int OW_SEGMENT_COUNT_LSB = 22;
    localparam int OW_SUBSEGMENT_COUNT_LSB = 20;
    localparam int OW_RD_LSB = 16;
    localparam int OW_WR_LSB = 12;
    localparam int TR_DEST_LSB = 22;
    localparam int TR_HOP_LSB = 12;
    localparam int TR_OFS_LSB = 0;
    localparam int TR_OFS_W = 12;
    localparam int ST_INIT_BIT = 0;
    localparam int ST_WIDE_BIT = 1;

    localparam logic [3:0] TGT_LINK = 4'hc;
    localparam logic [3:0] TT_MAINT = 4'h7;
    localparam logic [5:0] SIZE_MIN = 6'h0b;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LINK = 2'b01,
        ST_DONE = 2'b10
    } sow_state_e;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } sow_acc_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [TT_W-1:0] ttype;
        logic [1:0] prio;
        logic pci_order;
        logic [7:0] dest_id;
        logic [7:0] hop;
        logic [MOFS_W-1:0] offset;
        logic [31:0] wdata;
    } sow_link_req_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] data;
    } sow_link_rsp_s;

    typedef struct packed {
        sow_state_e fsm;
        logic acc_ready;
        logic done;
        logic err;
        logic [31:0] rdata;
        logic route_valid;
        logic [TGT_W-1:0] route_target;
        logic [ADDR_W-1:0] route_addr;
        sow_link_req_s req;
        logic [31:0] lw_base;
        logic [31:0] lw_attr;
        logic [31:0] ow_base;
        logic [31:0] ow_attr;
        logic [31:0] ow_trans;
        logic link_init;
        logic link_wide;
    } sow_regs_s;
endpackage : sow_pkg

// *** verilog/sow_decode.sv ***
// Power-of-two address window hit decoder with offset mask.
`timescale 1ns/1ps
`default_nettype none
module sow_decode (
    input wire logic en,
    input wire logic [sow_pkg::BASE_W-1:0] base,
    input wire logic [sow_pkg::SIZE_W-1:0] size,
    input wire logic [sow_pkg::ADDR_W-1:0] addr,
    output logic hit,
    output logic [sow_pkg::ADDR_W-1:0] offset_mask
);
    logic [sow_pkg::ADDR_W-1:0] keep;

    // The window spans two to the power (size + 1) bytes; bits above that are compared.
    for (genvar i = 0; i < sow_pkg::ADDR_W; i++) begin : g_bit
        assign keep[i] = (6'(i) > size);
        assign offset_mask[i] = ~keep[i];
    end

    // Encodings below the smallest page never decode, so a bad size cannot claim everything.
    assign hit = en && (size >= sow_pkg::SIZE_MIN)
        && (((addr[sow_pkg::ADDR_W-1:sow_pkg::PAGE_SHIFT] ^ base)
        & keep[sow_pkg::ADDR_W-1:sow_pkg::PAGE_SHIFT]) == '0);
endmodule : sow_decode
`default_nettype wire

// *** verilog/sow_bridge.sv ***
// Local access window and outbound maintenance window bridge toward the serial link.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - An access inside an enabled local window goes to the interface named by its target code, 0xc being the link.
// - The local base register holds the upper 24 bits of the 36-bit window start.
// - The local size field sets the window extent from the base, 0x1b meaning 256 megabytes.
// - Bit 31 of the local attributes enables the window, and a disabled window claims nothing.
// - The link initialized flag rises only with ports up and clean symbols, and no link traffic goes out before it.
// - A status bit reports whether the port came up one lane or four lanes wide.
// - The outbound base register holds address bits 32-35 and 12-31 of the 36-bit window start.
// - Only an enabled outbound window turns accesses into link transactions.
// - The two-bit priority field sets the priority of every request the window issues.
// - The ordering bit chooses whether requests follow PCI ordering, zero meaning not.
// - Segment and subsegment counts split the window, zero in each giving one plain window.
// - A read hitting the outbound window issues the read transaction code, 0x7 being maintenance read.
// - A write hitting the outbound window issues the write transaction code, 0x7 being maintenance write.
// - The outbound size field sets the window extent with the same power-of-two encoding.
// - The maintenance offset takes low bits from the window offset and high bits from the translation register.
// - The translation register gives destination id, hop count and upper maintenance offset bits.
module sow_bridge #(
    parameter logic [23:0] CFG_PAGE = 24'hf00000
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic ACC_VALID,
    input wire sow_pkg::sow_acc_s ACC,
    output logic ACC_READY,
    output logic ACC_DONE,
    output logic ACC_ERR,
    output logic [31:0] ACC_RDATA,
    output logic ROUTE_VALID,
    output logic [3:0] ROUTE_TARGET,
    output logic [35:0] ROUTE_ADDR,
    output sow_pkg::sow_link_req_s LINK_REQ,
    input wire sow_pkg::sow_link_rsp_s LINK_RSP,
    input wire logic PORT_INIT,
    input wire logic PORT_SYMBOLS_OK,
    input wire logic PORT_LANES4
);
    localparam sow_pkg::sow_regs_s RESET_VAL = '{
        fsm: sow_pkg::ST_IDLE,
        acc_ready: 1'b0,
        done: 1'b0,
        err: 1'b0,
        rdata: '0,
        route_valid: 1'b0,
        route_target: '0,
        route_addr: '0,
        req: '0,
        lw_base: sow_pkg::REG_RST,
        lw_attr: sow_pkg::REG_RST,
        ow_base: sow_pkg::REG_RST,
        ow_attr: sow_pkg::REG_RST,
        ow_trans: sow_pkg::REG_RST,
        link_init: 1'b0,
        link_wide: 1'b0
    };

    sow_pkg::sow_regs_s st_q;
    sow_pkg::sow_regs_s st_d;

    logic lw_hit;
    logic ow_hit;
    logic [35:0] lw_mask;
    logic [35:0] ow_mask;
    logic cfg_hit;
    logic accept;
    logic [11:0] cfg_ofs;
    logic [3:0] lw_target;
    logic [35:0] win_off;
    logic [3:0] seg_bits;
    logic [6:0] seg_shift;
    logic [7:0] seg_idx;
    logic [23:0] moff_mask;
    logic [23:0] maint_off;
    logic [31:0] stat_word;

    sow_decode u_local (
        .en(st_q.lw_attr[sow_pkg::EN_BIT]),
        .base(st_q.lw_base[sow_pkg::BASE_W-1:0]),
        .size(st_q.lw_attr[sow_pkg::SIZE_LSB +: sow_pkg::SIZE_W]),
        .addr(ACC.addr),
        .hit(lw_hit),
        .offset_mask(lw_mask)
    );

    // The outbound base field is the extended nibble followed by the low twenty bits.
    sow_decode u_outbound (
        .en(st_q.ow_attr[sow_pkg::EN_BIT]),
        .base(st_q.ow_base[sow_pkg::BASE_W-1:0]),
        .size(st_q.ow_attr[sow_pkg::SIZE_LSB +: sow_pkg::SIZE_W]),
        .addr(ACC.addr),
        .hit(ow_hit),
        .offset_mask(ow_mask)
    );

    assign accept = ACC_VALID && st_q.acc_ready;
    assign cfg_hit = (ACC.addr[35:sow_pkg::PAGE_SHIFT] == CFG_PAGE);
    assign cfg_ofs = ACC.addr[sow_pkg::PAGE_SHIFT-1:0];
    assign lw_target = st_q.lw_attr[sow_pkg::LW_TGT_LSB +: sow_pkg::TGT_W];
    assign win_off = ACC.addr & ow_mask;

    // Each segment bit doubles the targets; the segment index comes from the top offset bits.
    assign seg_bits = {2'b00, st_q.ow_attr[sow_pkg::OW_SEGMENT_COUNT_LSB +: 2]}
        + {2'b00, st_q.ow_attr[sow_pkg::OW_SUBSEGMENT_COUNT_LSB +: 2]};
    assign seg_shift = 7'(st_q.ow_attr[sow_pkg::SIZE_LSB +: sow_pkg::SIZE_W]) + 7'd1 - 7'(seg_bits);
    assign seg_idx = 8'(win_off >> seg_shift) & ((8'h01 << seg_bits) - 8'h01);

    assign moff_mask = ow_mask[sow_pkg::MOFS_W-1:0];
    assign maint_off = ((24'(st_q.ow_trans[sow_pkg::TR_OFS_LSB +: sow_pkg::TR_OFS_W]) << sow_pkg::PAGE_SHIFT)
        & ~moff_mask) | (win_off[sow_pkg::MOFS_W-1:0] & moff_mask);

    always_comb begin
        stat_word = '0;
        stat_word[sow_pkg::ST_INIT_BIT] = st_q.link_init;
        stat_word[sow_pkg::ST_WIDE_BIT] = st_q.link_wide;
    end

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.err = 1'b0;
        st_d.route_valid = 1'b0;
        st_d.req.valid = 1'b0;
        // Both conditions must hold before software may use the link.
        st_d.link_init = PORT_INIT && PORT_SYMBOLS_OK;
        st_d.link_wide = PORT_INIT && PORT_LANES4;
        unique case (st_q.fsm)
            sow_pkg::ST_IDLE: begin
                st_d.acc_ready = 1'b1;
                if (accept) begin
                    st_d.acc_ready = 1'b0;
                    st_d.fsm = sow_pkg::ST_DONE;
                    st_d.done = 1'b1;
                    st_d.rdata = '0;
                    if (cfg_hit) begin
                        unique case (cfg_ofs)
                            sow_pkg::OFS_LW_BASE: begin
                                st_d.rdata = st_q.lw_base;
                                if (ACC.write) begin
                                    st_d.lw_base = ACC.wdata & sow_pkg::MASK_BASE;
                                end
                            end
                            sow_pkg::OFS_LW_ATTR: begin
                                st_d.rdata = st_q.lw_attr;
                                if (ACC.write) begin
                                    st_d.lw_attr = ACC.wdata & sow_pkg::MASK_LW_ATTR;
                                end
                            end
                            sow_pkg::OFS_OW_BASE: begin
                                st_d.rdata = st_q.ow_base;
                                if (ACC.write) begin
                                    st_d.ow_base = ACC.wdata & sow_pkg::MASK_BASE;
                                end
                            end
                            sow_pkg::OFS_OW_ATTR: begin
                                st_d.rdata = st_q.ow_attr;
                                if (ACC.write) begin
                                    st_d.ow_attr = ACC.wdata & sow_pkg::MASK_OW_ATTR;
                                end
                            end
                            sow_pkg::OFS_OW_TRANS: begin
                                st_d.rdata = st_q.ow_trans;
                                if (ACC.write) begin
                                    st_d.ow_trans = ACC.wdata & sow_pkg::MASK_OW_TRANS;
                                end
                            end
                            sow_pkg::OFS_LINK_STAT: begin
                                st_d.rdata = stat_word;
                                st_d.err = ACC.write;
                            end
                            default: begin
                                st_d.err = 1'b1;
                            end
                        endcase
                    end else if (lw_hit && lw_target != sow_pkg::TGT_LINK) begin
                        // Other interfaces are served elsewhere; this block only steers the access.
                        st_d.route_valid = 1'b1;
                        st_d.route_target = lw_target;
                        st_d.route_addr = ACC.addr;
                    end else if (lw_hit && ow_hit && st_q.link_init) begin
                        st_d.done = 1'b0;
                        st_d.fsm = sow_pkg::ST_LINK;
                        st_d.req.valid = 1'b1;
                        st_d.req.write = ACC.write;
                        st_d.req.ttype = ACC.write
                            ? st_q.ow_attr[sow_pkg::OW_WR_LSB +: sow_pkg::TT_W]
                            : st_q.ow_attr[sow_pkg::OW_RD_LSB +: sow_pkg::TT_W];
                        st_d.req.prio = st_q.ow_attr[sow_pkg::OW_PRIO_LSB +: 2];
                        st_d.req.pci_order = st_q.ow_attr[sow_pkg::OW_PCI_BIT];
                        st_d.req.dest_id = st_q.ow_trans[sow_pkg::TR_DEST_LSB +: 8] + seg_idx;
                        st_d.req.hop = st_q.ow_trans[sow_pkg::TR_HOP_LSB +: 8];
                        st_d.req.offset = maint_off;
                        st_d.req.wdata = ACC.wdata;
                    end else begin
                        // No enabled window claims it, or the link is not up yet.
                        st_d.err = 1'b1;
                    end
                end
            end
            sow_pkg::ST_LINK: begin
                if (LINK_RSP.valid) begin
                    st_d.fsm = sow_pkg::ST_DONE;
                    st_d.done = 1'b1;
                    st_d.err = LINK_RSP.err;
                    st_d.rdata = st_q.req.write ? '0 : LINK_RSP.data;
                end
            end
            sow_pkg::ST_DONE: begin
                st_d.fsm = sow_pkg::ST_IDLE;
                st_d.acc_ready = 1'b1;
            end
            default: begin
                st_d.fsm = sow_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st_q <= RESET_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign ACC_READY = st_q.acc_ready;
    assign ACC_DONE = st_q.done;
    assign ACC_ERR = st_q.err;
    assign ACC_RDATA = st_q.rdata;
    assign ROUTE_VALID = st_q.route_valid;
    assign ROUTE_TARGET = st_q.route_target;
    assign ROUTE_ADDR = st_q.route_addr;
    assign LINK_REQ = st_q.req;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_status_read;
        accept && !ACC.write && cfg_hit && cfg_ofs == sow_pkg::OFS_LINK_STAT;
    endsequence

    sequence s_link_issue;
        accept && lw_hit && ow_hit && st_q.link_init && !cfg_hit && lw_target == sow_pkg::TGT_LINK;
    endsequence

    sequence s_route_issue;
        accept && !cfg_hit && lw_hit && lw_target != sow_pkg::TGT_LINK;
    endsequence

    a_route_target: assert property (s_route_issue |=> ROUTE_VALID && ACC_DONE
        && ROUTE_TARGET == $past(lw_target) && !LINK_REQ.valid)
        else $error("route output does not carry the window target");

    a_lw_enable_gate: assert property ((ROUTE_VALID || LINK_REQ.valid) |-> st_q.lw_attr[sow_pkg::EN_BIT])
        else $error("disabled local window claimed an access");

    a_link_init_gate: assert property (LINK_REQ.valid |-> $past(PORT_INIT && PORT_SYMBOLS_OK, 2))
        else $error("link request issued before the link was initialized");

    a_width_status: assert property (s_status_read |=> ACC_RDATA[sow_pkg::ST_WIDE_BIT]
        == $past(PORT_INIT && PORT_LANES4, 2))
        else $error("width status does not follow the port");

    a_ow_enable_gate: assert property (LINK_REQ.valid |-> st_q.ow_attr[sow_pkg::EN_BIT]
        && st_q.lw_attr[sow_pkg::LW_TGT_LSB +: sow_pkg::TGT_W] == sow_pkg::TGT_LINK)
        else $error("link request from a disabled or foreign window");

    a_req_attrs: assert property (s_link_issue |=> LINK_REQ.valid
        && LINK_REQ.prio == st_q.ow_attr[sow_pkg::OW_PRIO_LSB +: 2]
        && LINK_REQ.pci_order == st_q.ow_attr[sow_pkg::OW_PCI_BIT])
        else $error("request priority or ordering differs from the window");

    a_req_type: assert property (s_link_issue |=> LINK_REQ.ttype == (LINK_REQ.write
        ? st_q.ow_attr[sow_pkg::OW_WR_LSB +: sow_pkg::TT_W]
        : st_q.ow_attr[sow_pkg::OW_RD_LSB +: sow_pkg::TT_W]))
        else $error("transaction type does not match the access direction");

    a_maint_fields: assert property (s_link_issue |=> LINK_REQ.hop == st_q.ow_trans[sow_pkg::TR_HOP_LSB +: 8]
        && LINK_REQ.offset == $past(maint_off))
        else $error("maintenance hop or offset not taken from translation");

    a_no_stray: assert property (accept && !cfg_hit && !(lw_hit && (ow_hit || lw_target != sow_pkg::TGT_LINK))
        |=> ACC_DONE && ACC_ERR && !LINK_REQ.valid ##1 ACC_READY)
        else $error("unclaimed access was not refused");
endmodule : sow_bridge
`default_nettype wire

// *** testbench/sow_link_partner.sv ***
// Behavioural far-end link port that answers each request after a set delay.
`timescale 1ns/1ps
`default_nettype none
module sow_link_partner (
    input wire logic clk,
    input wire logic rstn,
    input wire sow_pkg::sow_link_req_s link_req,
    input wire logic [3:0] delay,
    input wire logic err_inj,
    output var sow_pkg::sow_link_rsp_s link_rsp
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [23:0] ofs_q;
    logic [31:0] junk_q;
    // Outside a response the lines toggle, so stale data can never pass for an answer.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            ofs_q <= 24'h000000;
            junk_q <= 32'h0f0f0f0f;
            link_rsp <= '0;
        end else begin
            junk_q <= ~junk_q;
            link_rsp <= {1'b0, junk_q[0], junk_q};
            if (link_req.valid) begin
                busy_q <= 1'b1;
                cnt_q <= delay;
                ofs_q <= link_req.offset;
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                link_rsp <= {1'b1, err_inj, ofs_q, 8'h5a};
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : sow_link_partner
`default_nettype wire

// *** testbench/test_sow_bridge.sv ***
// Self-checking bench for the outbound window bridge.
`timescale 1ns/1ps
`default_nettype none
module test_sow_bridge;
    localparam logic [23:0] PAGE = 24'hf00000;
    logic clk, rstn, acc_valid, acc_ready, acc_done, acc_err, route_valid;
    logic port_init, port_symbols_ok, port_lanes4, p_err, er, wr, pci;
    logic [31:0] acc_rdata, rd, wd;
    logic [3:0] route_target, p_delay, rdc, wrc;
    logic [35:0] route_addr, wofs;
    logic [1:0] prio, nsg, nss;
    logic [7:0] dest, hop;
    logic [11:0] tofs;
    logic [5:0] sz;
    sow_pkg::sow_acc_s acc;
    sow_pkg::sow_link_req_s link_req;
    sow_pkg::sow_link_rsp_s link_rsp;
    int n_fail = 0, num_checks = 0, n_req = 0, n_route = 0, lat, n0;
    logic [11:0] ofs [5] = '{sow_pkg::OFS_LW_BASE, sow_pkg::OFS_LW_ATTR, sow_pkg::OFS_OW_BASE,
                             sow_pkg::OFS_OW_ATTR, sow_pkg::OFS_OW_TRANS};
    logic [31:0] msk [5] = '{sow_pkg::MASK_BASE, sow_pkg::MASK_LW_ATTR, sow_pkg::MASK_BASE,
                             sow_pkg::MASK_OW_ATTR, sow_pkg::MASK_OW_TRANS};

    sow_bridge i_dut (.CLK(clk), .RSTN(rstn), .ACC_VALID(acc_valid), .ACC(acc), .ACC_READY(acc_ready),
        .ACC_DONE(acc_done), .ACC_ERR(acc_err), .ACC_RDATA(acc_rdata), .ROUTE_VALID(route_valid),
        .ROUTE_TARGET(route_target), .ROUTE_ADDR(route_addr), .LINK_REQ(link_req), .LINK_RSP(link_rsp),
        .PORT_INIT(port_init), .PORT_SYMBOLS_OK(port_symbols_ok), .PORT_LANES4(port_lanes4));
    sow_link_partner i_far (.clk(clk), .rstn(rstn), .link_req(link_req), .delay(p_delay),
        .err_inj(p_err), .link_rsp(link_rsp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulses are counted at the falling edge, where registered outputs have settled.
    always @(negedge clk) begin
        if (link_req.valid === 1'b1) n_req++;
        if (route_valid === 1'b1) n_route++;
    end

    task automatic end_of_test();
        $display("Checks %0d, failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Entered just after an edge; the request is held until an edge sees ready high.
    task automatic access(input logic w, input logic [35:0] a, input logic [31:0] d);
        int i;
        acc_valid = 1'b1;
        acc = {w, a, d};
        // Ready is looked at off the edge, so the edge after a settled high is the one that takes.
        for (i = 0; i < 100 && acc_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        acc_valid = 1'b0;
        for (lat = 0; lat < 100; lat++) begin
            if (acc_done === 1'b1) break;
            @(posedge clk);
            #1;
        end
        chk(acc_done, 1'b1);
        rd = acc_rdata;
        er = acc_err;
        @(posedge clk);
        #1;
    endtask : access

    task automatic wreg(input logic [11:0] o, input logic [31:0] v);
        access(1'b1, {PAGE, o}, v);
        chk({er, lat}, 0);
    endtask : wreg

    task automatic rreg(input logic [11:0] o, input logic [31:0] v);
        access(1'b0, {PAGE, o}, 32'h0);
        chk({er, lat, rd}, {33'h0, v});
    endtask : rreg

    task automatic refused(input logic w, input logic [35:0] a);
        n0 = n_req;
        access(w, a, 32'h0);
        chk({er, n_req}, {1'b1, n0});
    endtask : refused

    function automatic logic [23:0] exp_ofs(logic [5:0] s, logic [35:0] o, logic [11:0] t);
        logic [35:0] m;
        m = (36'h1 << (s + 1)) - 36'h1;
        return 24'((o & m) | ({12'h0, t, 12'h0} & ~m));
    endfunction : exp_ofs

    // Segment bits split the window; the top offset bits below the size pick the destination.
    function automatic logic [7:0] exp_dest(logic [7:0] d, logic [5:0] s, logic [35:0] o, logic [2:0] n);
        return d + 8'((o >> (s + 1 - n)) & ((36'h1 << n) - 36'h1));
    endfunction : exp_dest

    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end

    initial begin
        rstn = 1'b0;
        acc_valid = 1'b0;
        acc = '0;
        {port_init, port_symbols_ok, port_lanes4, p_err, p_delay} = '0;
        void'($urandom(89));
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        @(posedge clk);
        #1;
        for (int k = 0; k < 5; k++) begin
            rreg(ofs[k], sow_pkg::REG_RST);
            wreg(ofs[k], 32'hffffffff);
            rreg(ofs[k], msk[k]);
            wreg(ofs[k], 32'h0);
        end
        rreg(sow_pkg::OFS_LINK_STAT, 32'h0);
        refused(1'b1, {PAGE, sow_pkg::OFS_LINK_STAT});
        refused(1'b0, {PAGE, 12'h018});
        refused(1'b0, 36'h0c0000000);
        wreg(sow_pkg::OFS_LW_BASE, 32'h000c0000);
        wreg(sow_pkg::OFS_LW_ATTR, 32'h8030001b);
        access(1'b1, 36'h0cffffffc, 32'h0);
        chk({er, lat, n_route, route_target, route_addr}, {1'b0, 32'd0, 32'd1, 4'h3, 36'h0cffffffc});
        refused(1'b0, 36'h0d0000000);
        refused(1'b0, 36'h0bffffffc);
        chk(n_route, 1);
        wreg(sow_pkg::OFS_LW_ATTR, 32'h0030001b);
        refused(1'b0, 36'h0c0000000);
        wreg(sow_pkg::OFS_LW_ATTR, 32'h80c0001b);
        refused(1'b0, 36'h0c0000000);
        wreg(sow_pkg::OFS_OW_BASE, 32'h000c0000);
        wreg(sow_pkg::OFS_OW_ATTR, 32'h80077013);
        refused(1'b0, 36'h0c0000000);
        {port_init, port_symbols_ok, port_lanes4} = 3'b101;
        // Status bits are registered, so one edge passes before they read back.
        @(posedge clk);
        #1;
        rreg(sow_pkg::OFS_LINK_STAT, 32'h2);
        refused(1'b0, 36'h0c0000000);
        // The link is used only once the initialized flag reads back set.
        {port_symbols_ok, port_lanes4} = 2'b10;
        @(posedge clk);
        #1;
        rreg(sow_pkg::OFS_LINK_STAT, 32'h1);
        for (int k = 0; k < 16; k++) begin
            sz = ($urandom % 2) ? 6'h13 : sow_pkg::SIZE_MIN;
            {prio, pci, rdc, wrc, dest, hop, tofs, nsg, nss} = {$urandom, $urandom};
            // The first two passes keep the plain single-segment window.
            if (k < 2) {nsg, nss} = 4'h0;
            wreg(sow_pkg::OFS_OW_ATTR, {4'h8, prio, pci, 1'b0, nsg, nss, rdc, wrc, 6'h0, sz});
            wreg(sow_pkg::OFS_OW_TRANS, {2'h0, dest, 2'h0, hop, tofs});
            wofs = (k == 0) ? 36'h0 : ($urandom & ((36'h1 << (sz + 1)) - 36'h1) & ~36'h3);
            if (k == 1) wofs = (36'h1 << (sz + 1)) - 36'h4;
            {wr, wd} = {$urandom, $urandom};
            p_delay = $urandom % 6;
            p_err = ($urandom % 4) == 0;
            n0 = n_req;
            access(wr, 36'h0c0000000 + wofs, wd);
            chk(n_req, n0 + 1);
            chk({link_req.write, link_req.ttype}, {wr, wr ? wrc : rdc});
            chk({link_req.prio, link_req.pci_order}, {prio, pci});
            chk({link_req.dest_id, link_req.hop}, {exp_dest(dest, sz, wofs, 3'(nsg) + 3'(nss)), hop});
            chk(link_req.offset, exp_ofs(sz, wofs, tofs));
            if (wr) chk(link_req.wdata, wd);
            chk({er, rd}, {p_err, wr ? 32'h0 : {exp_ofs(sz, wofs, tofs), 8'h5a}});
        end
        refused(1'b0, 36'h0c0000000 + (36'h1 << (sz + 1)));
        wreg(sow_pkg::OFS_OW_ATTR, 32'h00077013);
        refused(1'b1, 36'h0c0000000);
        end_of_test();
    end
endmodule : test_sow_bridge
`default_nettype wire
